// >>> rsd_cfg.svh
// timing counts and selector encodings for the reset start-up delay block
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH
// time-out selector codes
`define RSD_TO_SEL_ZERO 2'h0
`define RSD_TO_SEL_4K   2'h1
`define RSD_TO_SEL_8K   2'h2
// time-out counts in watchdog oscillator cycles
`define RSD_TO_CYC_4K   16'h1000
`define RSD_TO_CYC_8K   16'h2000
// start-up counts in system oscillator cycles
`define RSD_SU_CYC_EXT  16'h0006
`define RSD_SU_CYC_RC   16'h0006
`define RSD_SU_CYC_XTAL 16'h4000
`define RSD_SU_CYC_LFX  16'h8000
// clock type codes
`define RSD_CLK_EXT     2'h0
`define RSD_CLK_RC      2'h1
`define RSD_CLK_XTAL    2'h2
`define RSD_CLK_LFX     2'h3
`endif

// >>> rsd_pkg.sv
// types for the reset start-up delay block
package rsd_pkg;
   typedef enum logic [2:0] {
      RSD_HOLD, RSD_TIMEOUT, RSD_STARTUP, RSD_RUN, RSD_SLEEP
   } rsd_state_type;
endpackage : rsd_pkg

// >>> rsd_edge_cnt.sv
// edge counter for a slow clock sampled on the reference clock
`timescale 1ns/10ps
`default_nettype none
module rsd_edge_cnt (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        pin,
   input  wire logic        clear,
   input  wire logic [15:0] target,
   output logic             done
);
   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        s3;
      logic [15:0] cnt;
   } rsd_ec_type;
   rsd_ec_type q, d;

   // s1 is read only by s2; s3 gives the edge history
   always_comb begin
      d = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (clear) begin
         d.cnt = 16'h0000;
      end else if (q.s2 && !q.s3 && q.cnt != target) begin
         d.cnt = q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = !clear && (q.cnt == target);
endmodule : rsd_edge_cnt
`default_nettype wire

// >>> rsd_top.sv
// reset start-up delay sequencer top level
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "rsd_cfg.svh"
module rsd_top (
   input  wire logic       REF_CLK,
   input  wire logic       RESET,
   input  wire logic       WDT_OSC,
   input  wire logic       SYS_OSC,
   input  wire logic [1:0] TIMEOUT_SEL,
   input  wire logic [1:0] CLK_TYPE,
   input  wire logic       BOD_ENABLE,
   input  wire logic       BOD_OK,
   input  wire logic       SLEEP_REQ,
   input  wire logic       WAKE,
   output logic            CORE_RESET,
   output logic            CLOCK_STABLE
);
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [15:0] to_count(input logic [1:0] sel);
      case (sel)
         `RSD_TO_SEL_4K: to_count = `RSD_TO_CYC_4K;
         `RSD_TO_SEL_8K: to_count = `RSD_TO_CYC_8K;
         default:        to_count = 16'h0000;
      endcase
   endfunction : to_count

   function automatic logic [15:0] su_count(input logic [1:0] ct);
      case (ct)
         `RSD_CLK_EXT:  su_count = `RSD_SU_CYC_EXT;
         `RSD_CLK_RC:   su_count = `RSD_SU_CYC_RC;
         `RSD_CLK_XTAL: su_count = `RSD_SU_CYC_XTAL;
         default:       su_count = `RSD_SU_CYC_LFX;
      endcase
   endfunction : su_count

   typedef struct packed {
      rsd_pkg::rsd_state_type st;
      logic [1:0]             bod_s;
      logic [1:0]             wake_s;
      logic [1:0]             slp_s;
      logic [1:0]             ben_s;
      logic [1:0]             sel_m;
      logic [1:0]             sel_s;
      logic [1:0]             typ_m;
      logic [1:0]             typ_s;
      logic                   core_rst;
      logic                   stable;
   } rsd_top_type;
   rsd_top_type q, d;

   logic to_done;
   logic su_done;
   logic to_clr;
   logic su_clr;

   // counters clear while their phase is not active
   assign to_clr = (q.st != rsd_pkg::RSD_TIMEOUT);
   assign su_clr = (q.st != rsd_pkg::RSD_STARTUP);

   // ------------------------------------------------------------------
   // counters
   // ------------------------------------------------------------------
   // pure cycle count of the watchdog clock, no supply input
   rsd_edge_cnt u_to (
      .clk    (REF_CLK),
      .rst    (RESET),
      .pin    (WDT_OSC),
      .clear  (to_clr),
      .target (to_count(q.sel_s)),
      .done   (to_done)
   );

   // synchronised edge count of oscillator cycles by clock type
   rsd_edge_cnt u_su (
      .clk    (REF_CLK),
      .rst    (RESET),
      .pin    (SYS_OSC),
      .clear  (su_clr),
      .target (su_count(q.typ_s)),
      .done   (su_done)
   );

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   // pins synchronised; only bit 1 of each pair is used by logic
   always_comb begin
      d = q;
      d.bod_s  = {q.bod_s[0], BOD_OK};
      d.wake_s = {q.wake_s[0], WAKE};
      d.slp_s  = {q.slp_s[0], SLEEP_REQ};
      // straps are pins too; hold waits until they have settled
      d.ben_s  = {q.ben_s[0], BOD_ENABLE};
      d.sel_m  = TIMEOUT_SEL;
      d.sel_s  = q.sel_m;
      d.typ_m  = CLK_TYPE;
      d.typ_s  = q.typ_m;
      case (q.st)
         // brown-out keeps reset until the supply is good
         rsd_pkg::RSD_HOLD: begin
            if (!q.ben_s[1] || q.bod_s[1]) begin
               d.st = rsd_pkg::RSD_TIMEOUT;
            end
         end
         // time-out first; zero setting finishes at once
         rsd_pkg::RSD_TIMEOUT: begin
            if (to_done) begin
               d.st = rsd_pkg::RSD_STARTUP;
            end
         end
         rsd_pkg::RSD_STARTUP: begin
            if (su_done) begin
               d.st = rsd_pkg::RSD_RUN;
            end
         end
         rsd_pkg::RSD_RUN: begin
            if (q.slp_s[1]) begin
               d.st = rsd_pkg::RSD_SLEEP;
            end
         end
         // wake skips the time-out phase
         rsd_pkg::RSD_SLEEP: begin
            if (q.wake_s[1]) begin
               d.st = rsd_pkg::RSD_STARTUP;
            end
         end
         default: d.st = rsd_pkg::RSD_HOLD;
      endcase
      d.core_rst = (d.st != rsd_pkg::RSD_RUN) &&
                   (d.st != rsd_pkg::RSD_SLEEP);
      d.stable   = (d.st == rsd_pkg::RSD_RUN);
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         q.st       <= rsd_pkg::RSD_HOLD;
         q.bod_s    <= 2'h0;
         q.wake_s   <= 2'h0;
         q.slp_s    <= 2'h0;
         q.ben_s    <= 2'h3; // assume brown-out in use until seen
         q.sel_m    <= 2'h0;
         q.sel_s    <= 2'h0;
         q.typ_m    <= 2'h0;
         q.typ_s    <= 2'h0;
         q.core_rst <= 1'b1;
         q.stable   <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // registered outputs
   assign CORE_RESET   = q.core_rst;
   assign CLOCK_STABLE = q.stable;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   release_order_a: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      $fell(q.core_rst) |-> $past(q.st) == rsd_pkg::RSD_STARTUP)
      else $error("reset released outside start-up phase");

   startup_done_a: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (q.st == rsd_pkg::RSD_STARTUP && su_done)
      |=> q.st == rsd_pkg::RSD_RUN ##1 !q.core_rst)
      else $error("start-up end did not release reset");

   timeout_hold_a: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (q.st == rsd_pkg::RSD_TIMEOUT && !to_done)
      |=> q.st == rsd_pkg::RSD_TIMEOUT && q.core_rst)
      else $error("time-out left before count reached");

   timeout_next_a: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (q.st == rsd_pkg::RSD_TIMEOUT && to_done)
      |=> q.st == rsd_pkg::RSD_STARTUP)
      else $error("time-out not followed by start-up");

   wake_skip_a: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (q.st == rsd_pkg::RSD_SLEEP && q.wake_s[1])
      |=> q.st == rsd_pkg::RSD_STARTUP)
      else $error("wake did not go straight to start-up");

   bod_hold_a: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (q.st == rsd_pkg::RSD_HOLD && q.ben_s[1] && !q.bod_s[1])
      |=> q.st == rsd_pkg::RSD_HOLD && q.core_rst)
      else $error("left hold without supply good");

   su_held_a: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (q.st == rsd_pkg::RSD_STARTUP && !su_done)
      |=> q.core_rst && q.st == rsd_pkg::RSD_STARTUP)
      else $error("reset dropped during start-up count");

   stable_match_a: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      $rose(q.stable) |->
      $past(q.st) == rsd_pkg::RSD_STARTUP && $past(su_done))
      else $error("stable flag rose before start-up count ended");

   run_reach_c: cover property (
      @(posedge REF_CLK) disable iff (RESET) $fell(q.core_rst));
   sleep_wake_c: cover property (
      @(posedge REF_CLK) disable iff (RESET)
      q.st == rsd_pkg::RSD_SLEEP ##1 q.st == rsd_pkg::RSD_STARTUP);
   zero_to_c: cover property (
      @(posedge REF_CLK) disable iff (RESET)
      q.st == rsd_pkg::RSD_TIMEOUT && q.sel_s == `RSD_TO_SEL_ZERO);
   bod_wait_c: cover property (
      @(posedge REF_CLK) disable iff (RESET)
      q.st == rsd_pkg::RSD_HOLD ##1 q.st == rsd_pkg::RSD_TIMEOUT);
endmodule : rsd_top
`default_nettype wire

// >>> rsd_osc_model.sv
// free-running oscillator model for the slow clock pins
`timescale 1ns/10ps
`default_nettype none
module rsd_osc_model #(
   parameter int HALF_NS  = 80,
   parameter int START_NS = 3
) (
   output var logic osc
);
   // a real oscillator never stops, so neither does this one
   initial begin
      osc = 1'b0;
      #(START_NS);
      forever #(HALF_NS) osc = ~osc;
   end
endmodule : rsd_osc_model
`default_nettype wire

// >>> tb_rsd_top.sv
// self-checking testbench for the reset start-up delay sequencer
`timescale 1ns/10ps
`default_nettype none
`include "rsd_cfg.svh"
module tb_rsd_top;
   logic       REF_CLK = 1'b0, RESET = 1'b1, BOD_ENABLE = 1'b0;
   logic       BOD_OK = 1'b0, SLEEP_REQ = 1'b0, WAKE = 1'b0;
   logic [1:0] TIMEOUT_SEL = 2'h0, CLK_TYPE = 2'h0;
   logic       WDT_OSC, SYS_OSC, CORE_RESET, CLOCK_STABLE;
   int         err_total = 0, checks_done = 0, cyc = 0;

   // -----------------------------------------------------------------
   // clock, far side and design
   // -----------------------------------------------------------------
   always #10 REF_CLK = ~REF_CLK;
   rsd_osc_model #(.HALF_NS(80), .START_NS(3)) wdt_i (.osc(WDT_OSC));
   rsd_osc_model #(.HALF_NS(80), .START_NS(37)) sys_i (.osc(SYS_OSC));
   rsd_top rsd_top_i (
      .REF_CLK(REF_CLK), .RESET(RESET), .WDT_OSC(WDT_OSC),
      .SYS_OSC(SYS_OSC), .TIMEOUT_SEL(TIMEOUT_SEL), .CLK_TYPE(CLK_TYPE),
      .BOD_ENABLE(BOD_ENABLE), .BOD_OK(BOD_OK), .SLEEP_REQ(SLEEP_REQ),
      .WAKE(WAKE), .CORE_RESET(CORE_RESET), .CLOCK_STABLE(CLOCK_STABLE)
   );

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask : chk

   // six cycles of reset; the straps are set while it is held
   task automatic do_reset(input logic [1:0] sel, input logic [1:0] typ,
                           input logic bod);
      @(posedge REF_CLK);
      RESET <= 1'b1;
      TIMEOUT_SEL <= sel;
      CLK_TYPE <= typ;
      BOD_ENABLE <= bod;
      BOD_OK <= ~bod;
      repeat (6) @(posedge REF_CLK);
      RESET <= 1'b0;
   endtask : do_reset

   // cycles until core reset drops, bounded so a hang cannot stall us
   task automatic wait_low(output int n, input int lim);
      n = 0;
      while (CORE_RESET !== 1'b0 && n < lim) begin
         @(posedge REF_CLK);
         #1;
         n++;
      end
   endtask : wait_low

   // -----------------------------------------------------------------
   // scenarios; oscillator cycle is 8 reference cycles
   // -----------------------------------------------------------------
   task automatic sc_bod_hold;
      int n;
      do_reset(`RSD_TO_SEL_ZERO, `RSD_CLK_EXT, 1'b1);
      repeat (200) @(posedge REF_CLK);
      #1;
      chk("reset held on low supply", CORE_RESET, 1'b1);
      chk("not stable while held", CLOCK_STABLE, 1'b0);
      @(posedge REF_CLK);
      BOD_OK <= 1'b1;
      wait_low(n, 200);
      chk("zero time-out release", n >= 36 && n <= 70, 1'b1);
      chk("stable after release", CLOCK_STABLE, 1'b1);
   endtask : sc_bod_hold

   // code 3 behaves as no time-out at all
   task automatic sc_sel_three;
      int n;
      do_reset(2'h3, `RSD_CLK_EXT, 1'b0);
      wait_low(n, 200);
      chk("code 3 release time", n >= 40 && n <= 70, 1'b1);
   endtask : sc_sel_three

   // crystal types must hold reset well past six oscillator cycles
   task automatic sc_slow_clock;
      do_reset(`RSD_TO_SEL_ZERO, `RSD_CLK_XTAL, 1'b0);
      repeat (300) @(posedge REF_CLK);
      #1;
      chk("crystal start-up held", CORE_RESET, 1'b1);
      do_reset(`RSD_TO_SEL_ZERO, `RSD_CLK_LFX, 1'b0);
      repeat (300) @(posedge REF_CLK);
      #1;
      chk("slow crystal held", CORE_RESET, 1'b1);
   endtask : sc_slow_clock

   // 4096 watchdog cycles then 6 system cycles, in that order
   task automatic sc_timeout_4k;
      int n;
      do_reset(`RSD_TO_SEL_4K, `RSD_CLK_RC, 1'b0);
      wait_low(n, 40000);
      chk("4k release time", n >= 32790 && n <= 32840, 1'b1);
      chk("stable after 4k", CLOCK_STABLE, 1'b1);
   endtask : sc_timeout_4k

   // wake skips the time-out although a 4k one is still selected
   task automatic sc_sleep_wake;
      int n;
      @(posedge REF_CLK);
      SLEEP_REQ <= 1'b1;
      repeat (6) @(posedge REF_CLK);
      #1;
      chk("sleep clears stable", CLOCK_STABLE, 1'b0);
      chk("sleep keeps reset low", CORE_RESET, 1'b0);
      @(posedge REF_CLK);
      SLEEP_REQ <= 1'b0;
      WAKE <= 1'b1;
      repeat (6) @(posedge REF_CLK);
      #1;
      chk("wake holds reset", CORE_RESET, 1'b1);
      wait_low(n, 200);
      chk("wake start-up only", n <= 70, 1'b1);
      @(posedge REF_CLK);
      WAKE <= 1'b0;
   endtask : sc_sleep_wake

   // past the 4k mark an 8k choice must still hold reset
   task automatic sc_timeout_8k;
      do_reset(`RSD_TO_SEL_8K, `RSD_CLK_EXT, 1'b0);
      repeat (4096 * 8 + 300) @(posedge REF_CLK);
      #1;
      chk("8k still in reset", CORE_RESET, 1'b1);
   endtask : sc_timeout_8k

   // -----------------------------------------------------------------
   // main sequence and hang guard
   // -----------------------------------------------------------------
   initial begin
      sc_bod_hold();
      sc_sel_three();
      sc_slow_clock();
      sc_timeout_4k();
      sc_sleep_wake();
      sc_timeout_8k();
      give_verdict();
   end

   // whole plan needs about 67k cycles
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == 75000) begin
         err_total++;
         give_verdict();
      end
   end
endmodule : tb_rsd_top
`default_nettype wire
